// ===== shared/stpidx_defines.svh
`ifndef STPIDX_DEFINES_SVH
`define STPIDX_DEFINES_SVH
// register offsets (byte addresses)
`define STPIDX_OFF_GLOBAL_CONFIG   8'h00
`define STPIDX_OFF_VELOCITY        8'h04
`define STPIDX_OFF_STEP_INTERVAL   8'h08
`define STPIDX_OFF_POSITION        8'h0C
`define STPIDX_OFF_DRIVER_STATUS   8'h10
// global_config fields
`define STPIDX_CFG_INDEX_STEP      0
`define STPIDX_CFG_DRV_ENABLE      1
`define STPIDX_CFG_TSEL_LSB        2
`define STPIDX_CFG_TSEL_MSB        3
`define STPIDX_CFG_RESET           32'h0000_0002
// driver_status fields
`define STPIDX_ST_OT               0
`define STPIDX_ST_OTPW             1
`define STPIDX_ST_BRIDGE_A_GROUND_SHORT_FLAG             2
`define STPIDX_ST_BRIDGE_B_GROUND_SHORT_FLAG             3
`define STPIDX_ST_BRIDGE_A_SUPPLY_SHORT_FLAG            4
`define STPIDX_ST_BRIDGE_B_SUPPLY_SHORT_FLAG            5
`define STPIDX_ST_BRIDGE_A_OFF     6
`define STPIDX_ST_BRIDGE_B_OFF     7
// sequencer and short protection
`define STPIDX_POS_WIDTH           10
`define STPIDX_VEL_WIDTH           24
`define STPIDX_ACC_WIDTH           24
`define STPIDX_TIMER_WIDTH         20
`define STPIDX_TIMER_MAX           20'h F_FFFF
`define STPIDX_SHORT_RETRIES       3
`endif

// ===== shared/stpidx_pkg.sv
package stpidx_pkg;
	typedef enum logic [1:0] {
		STPIDX_TH_143 = 2'd0,
		STPIDX_TH_150_PW120 = 2'd1,
		STPIDX_TH_150_PW143 = 2'd2,
		STPIDX_TH_157 = 2'd3
	} stpidx_thsel_e;
	typedef enum {
		STPIDX_SC_IDLE,
		STPIDX_SC_RETRY,
		STPIDX_SC_LATCHED
	} stpidx_short_e;
endpackage

// ===== verilog/stpidx_short_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "stpidx_defines.svh"
module stpidx_short_guard #(
	parameter int RETRIES = `STPIDX_SHORT_RETRIES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// control
	input  wire logic drv_enable,
	input  wire logic short_gnd,
	input  wire logic short_sup,
	// results
	output logic      bridge_off,
	output logic      gnd_flag,
	output logic      sup_flag
);
	stpidx_pkg::stpidx_short_e state_reg;
	logic [1:0]                tries_reg;
	logic                      prev_reg;
	logic                      hit;
	logic                      rise;

	assign hit  = short_gnd | short_sup;
	assign rise = hit & ~prev_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= hit;
		end
	end

	// each fresh detection is one retry; the next fresh detection after the retries latches
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg  <= stpidx_pkg::STPIDX_SC_IDLE;
			tries_reg  <= 2'd0;
			gnd_flag   <= 1'b0;
			sup_flag   <= 1'b0;
			bridge_off <= 1'b0;
		end else if (!drv_enable) begin
			// a reset or disabling the driver are the only exits from a latched short
			state_reg  <= stpidx_pkg::STPIDX_SC_IDLE;
			tries_reg  <= 2'd0;
			gnd_flag   <= 1'b0;
			sup_flag   <= 1'b0;
			bridge_off <= 1'b0;
		end else begin
			unique case (state_reg)
				stpidx_pkg::STPIDX_SC_IDLE: begin
					if (rise) begin
						state_reg <= stpidx_pkg::STPIDX_SC_RETRY;
						tries_reg <= 2'd1;
					end
				end
				stpidx_pkg::STPIDX_SC_RETRY: begin
					if (rise) begin
						if (tries_reg == 2'(RETRIES)) begin
							state_reg  <= stpidx_pkg::STPIDX_SC_LATCHED;
							bridge_off <= 1'b1;
							gnd_flag   <= short_gnd;
							sup_flag   <= short_sup;
						end else begin
							tries_reg <= tries_reg + 2'd1;
						end
					end
				end
				stpidx_pkg::STPIDX_SC_LATCHED: begin
					state_reg <= stpidx_pkg::STPIDX_SC_LATCHED;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== verilog/stpidx_core.sv
// How it works
// - index active at sequence zero point
// - index once per four full steps
// - step rate velocity times clock/2/2^23
// - velocity is two's complement signed
// - step interval counted in clock cycles
// - index-as-step option toggles each step
// - position wraps 1023 to 0
// - prewarn and shutdown flags, selectable thresholds
// - default shutdown 143, prewarn 120
// - 150 shutdown via serial or OTP
// - 157 shutdown only via serial
// - shutdown holds until below prewarn
// - short confirmed after three retries
// - only affected bridge off, flag set
// - short latched until driver re-enabled
// - direction 0 counts up, 1 down
// - 1024-entry table indexed by counter
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "stpidx_defines.svh"
module stpidx_core #(
	parameter int POS_W   = `STPIDX_POS_WIDTH,
	parameter int VEL_W   = `STPIDX_VEL_WIDTH,
	parameter int TIMER_W = `STPIDX_TIMER_WIDTH
) (
	// clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RESET_N,
	// register port
	input  wire logic [7:0]        ADDR,
	input  wire logic [31:0]       WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic [31:0]            RDATA,
	// step pins
	input  wire logic              STEP_PIN,
	input  wire logic              DIR_PIN,
	input  wire logic [8:0]        STEP_WIDTH,
	// otp threshold settings
	input  wire logic              OTP_TH_150,
	input  wire logic              OTP_PW_143,
	// analog comparators, one per threshold
	input  wire logic              TEMP_ABOVE_120,
	input  wire logic              TEMP_ABOVE_143,
	input  wire logic              TEMP_ABOVE_150,
	input  wire logic              TEMP_ABOVE_157,
	// short detectors
	input  wire logic              SHORT_GND_A,
	input  wire logic              SHORT_SUP_A,
	input  wire logic              SHORT_GND_B,
	input  wire logic              SHORT_SUP_B,
	// outputs
	output logic                   INDEX,
	output logic                   BRIDGE_A_EN,
	output logic                   BRIDGE_B_EN,
	output logic [POS_W-1:0]       MICROSTEP_POSITION
);
	// synchronisers for pins
	logic [1:0] step_sync_reg;
	logic [1:0] dir_sync_reg;
	logic [3:0] tmp_s1_reg;
	logic [3:0] tmp_s2_reg;
	logic [3:0] sh_s1_reg;
	logic [3:0] sh_s2_reg;
	logic       step_prev_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			step_sync_reg <= 2'b00;
			dir_sync_reg  <= 2'b00;
			tmp_s1_reg    <= 4'h0;
			tmp_s2_reg    <= 4'h0;
			sh_s1_reg     <= 4'h0;
			sh_s2_reg     <= 4'h0;
			step_prev_reg <= 1'b0;
		end else begin
			step_sync_reg <= {step_sync_reg[0], STEP_PIN};
			dir_sync_reg  <= {dir_sync_reg[0], DIR_PIN};
			tmp_s1_reg    <= {TEMP_ABOVE_157, TEMP_ABOVE_150, TEMP_ABOVE_143, TEMP_ABOVE_120};
			tmp_s2_reg    <= tmp_s1_reg;
			sh_s1_reg     <= {SHORT_SUP_B, SHORT_GND_B, SHORT_SUP_A, SHORT_GND_A};
			sh_s2_reg     <= sh_s1_reg;
			step_prev_reg <= step_sync_reg[1];
		end
	end

	// registers
	logic [31:0]      global_config_reg;
	logic [VEL_W-1:0] internal_velocity_reg;
	logic             otp_cap_reg;
	logic             otp_150_reg;
	logic             otp_pw143_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			global_config_reg     <= `STPIDX_CFG_RESET;
			internal_velocity_reg <= '0;
		end else if (WR) begin
			if (ADDR == `STPIDX_OFF_GLOBAL_CONFIG) begin
				global_config_reg <= {28'h000_0000, WDATA[3:0]};
			end
			if (ADDR == `STPIDX_OFF_VELOCITY) begin
				internal_velocity_reg <= WDATA[VEL_W-1:0];
			end
		end
	end

	// otp straps caught once after reset release
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			otp_cap_reg   <= 1'b0;
			otp_150_reg   <= 1'b0;
			otp_pw143_reg <= 1'b0;
		end else if (!otp_cap_reg) begin
			otp_cap_reg   <= 1'b1;
			otp_150_reg   <= OTP_TH_150;
			otp_pw143_reg <= OTP_PW_143;
		end
	end

	logic index_step_opt;
	logic drv_enable;
	assign index_step_opt = global_config_reg[`STPIDX_CFG_INDEX_STEP];
	assign drv_enable     = global_config_reg[`STPIDX_CFG_DRV_ENABLE];

	// internal velocity accumulator: carry out of 24 bits = clk/2^24 * |v| = clk/2/2^23 * |v|
	logic signed [VEL_W-1:0] vel_s;
	logic [VEL_W-1:0]        vel_mag;
	logic [VEL_W:0]          acc_sum;
	logic [VEL_W-1:0]        acc_reg;
	logic                    int_active;
	logic                    int_step;
	logic                    ext_step;
	logic                    step_evt;
	logic                    step_dir;

	assign vel_s      = $signed(internal_velocity_reg);
	assign vel_mag    = vel_s[VEL_W-1] ? VEL_W'(-vel_s) : internal_velocity_reg;
	assign int_active = (internal_velocity_reg != '0);
	assign acc_sum    = {1'b0, acc_reg} + {1'b0, vel_mag};
	assign int_step   = int_active & acc_sum[VEL_W];
	assign ext_step   = ~int_active & step_sync_reg[1] & ~step_prev_reg;
	assign step_evt   = int_step | ext_step;
	assign step_dir   = int_active ? vel_s[VEL_W-1] : dir_sync_reg[1];

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			acc_reg <= '0;
		end else if (int_active) begin
			acc_reg <= acc_sum[VEL_W-1:0];
		end else begin
			acc_reg <= '0;
		end
	end

	// microstep position indexes the 1024-entry table; natural wrap
	logic [POS_W-1:0] pos_reg;
	logic [POS_W-1:0] pos_next;
	logic [POS_W-1:0] inc;

	assign inc = int_active ? POS_W'(1) : POS_W'(STEP_WIDTH);

	always_comb begin
		pos_next = pos_reg;
		if (step_evt) begin
			if (step_dir) begin
				pos_next = pos_reg - inc;
			end else begin
				pos_next = pos_reg + inc;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			pos_reg <= '0;
		end else begin
			pos_reg <= pos_next;
		end
	end

	assign MICROSTEP_POSITION = pos_reg;

	// step interval in clock cycles; the counter saturates, and a step taken at saturation captures 0
	logic [TIMER_W-1:0] tcnt_reg;
	logic [TIMER_W-1:0] step_interval_clocks_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tcnt_reg                 <= '0;
			step_interval_clocks_reg <= `STPIDX_TIMER_MAX;
		end else if (step_evt) begin
			step_interval_clocks_reg <= tcnt_reg + TIMER_W'(1);
			tcnt_reg                 <= '0;
		end else if (tcnt_reg != `STPIDX_TIMER_MAX) begin
			tcnt_reg <= tcnt_reg + TIMER_W'(1);
			if (tcnt_reg + TIMER_W'(1) > step_interval_clocks_reg) begin
				step_interval_clocks_reg <= tcnt_reg + TIMER_W'(1);
			end
		end
	end

	// index: zero point is position 0, reached once per 1024-entry wave
	logic toggle_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			toggle_reg <= 1'b0;
		end else if (step_evt) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			INDEX <= 1'b0;
		end else if (index_step_opt) begin
			INDEX <= ~toggle_reg & step_evt | toggle_reg & ~step_evt;
		end else begin
			INDEX <= (pos_next == '0);
		end
	end

	// thresholds: serial selection overrides otp when nonzero; 157 is serial only
	stpidx_pkg::stpidx_thsel_e thsel;
	logic                      above_pw;
	logic                      above_sd;
	logic                      ot_reg;

	always_comb begin
		thsel = stpidx_pkg::stpidx_thsel_e'(global_config_reg[`STPIDX_CFG_TSEL_MSB:`STPIDX_CFG_TSEL_LSB]);
		if (thsel == stpidx_pkg::STPIDX_TH_143 && otp_150_reg) begin
			thsel = otp_pw143_reg ? stpidx_pkg::STPIDX_TH_150_PW143 : stpidx_pkg::STPIDX_TH_150_PW120;
		end
		unique case (thsel)
			stpidx_pkg::STPIDX_TH_143: begin
				above_sd = tmp_s2_reg[1];
				above_pw = tmp_s2_reg[0];
			end
			stpidx_pkg::STPIDX_TH_150_PW120: begin
				above_sd = tmp_s2_reg[2];
				above_pw = tmp_s2_reg[0];
			end
			stpidx_pkg::STPIDX_TH_150_PW143: begin
				above_sd = tmp_s2_reg[2];
				above_pw = tmp_s2_reg[1];
			end
			stpidx_pkg::STPIDX_TH_157: begin
				above_sd = tmp_s2_reg[3];
				above_pw = tmp_s2_reg[1];
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ot_reg <= 1'b0;
		end else if (above_sd) begin
			ot_reg <= 1'b1;
		end else if (!above_pw) begin
			ot_reg <= 1'b0;
		end
	end

	// short protection per bridge
	logic a_off;
	logic b_off;
	logic a_gnd;
	logic a_sup;
	logic b_gnd;
	logic b_sup;

	stpidx_short_guard u_guard_a (
		.clk        (CLK_SYS),
		.reset_n    (RESET_N),
		.drv_enable (drv_enable),
		.short_gnd  (sh_s2_reg[0]),
		.short_sup  (sh_s2_reg[1]),
		.bridge_off (a_off),
		.gnd_flag   (a_gnd),
		.sup_flag   (a_sup)
	);

	stpidx_short_guard u_guard_b (
		.clk        (CLK_SYS),
		.reset_n    (RESET_N),
		.drv_enable (drv_enable),
		.short_gnd  (sh_s2_reg[2]),
		.short_sup  (sh_s2_reg[3]),
		.bridge_off (b_off),
		.gnd_flag   (b_gnd),
		.sup_flag   (b_sup)
	);

	assign BRIDGE_A_EN = drv_enable & ~ot_reg & ~a_off;
	assign BRIDGE_B_EN = drv_enable & ~ot_reg & ~b_off;

	logic [7:0] status_word;
	assign status_word = {b_off, a_off, b_sup, a_sup, b_gnd, a_gnd, above_pw, ot_reg};

	// read data one cycle after strobe, zero otherwise and for unmapped
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			RDATA <= 32'h0000_0000;
		end else if (RD) begin
			unique case (ADDR)
				`STPIDX_OFF_GLOBAL_CONFIG: RDATA <= global_config_reg;
				`STPIDX_OFF_VELOCITY:      RDATA <= 32'(internal_velocity_reg);
				`STPIDX_OFF_STEP_INTERVAL: RDATA <= 32'(step_interval_clocks_reg);
				`STPIDX_OFF_POSITION:      RDATA <= 32'(pos_reg);
				`STPIDX_OFF_DRIVER_STATUS: RDATA <= {24'h00_0000, status_word};
				default:                   RDATA <= 32'h0000_0000;
			endcase
		end else begin
			RDATA <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ===== dv/stpidx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module stpidx_monitor #(
	parameter int POS_W = 10
) (
	// clock and reset
	input wire logic             CLK_SYS,
	input wire logic             RESET_N,
	// register port
	input wire logic [7:0]       ADDR,
	input wire logic [31:0]      WDATA,
	input wire logic             WR,
	input wire logic             RD,
	input wire logic [31:0]      RDATA,
	// sensing inputs
	input wire logic [8:0]       STEP_WIDTH,
	input wire logic             TEMP_ABOVE_143,
	input wire logic             SHORT_GND_A,
	input wire logic             SHORT_SUP_A,
	input wire logic             SHORT_GND_B,
	input wire logic             SHORT_SUP_B,
	// outputs
	input wire logic             INDEX,
	input wire logic             BRIDGE_A_EN,
	input wire logic             BRIDGE_B_EN,
	input wire logic [POS_W-1:0] MICROSTEP_POSITION
);
	logic [3:0]       cfg_reg;
	logic             vnz_reg;
	logic             vnzd_reg;
	logic [7:0]       hot_a_reg;
	logic [7:0]       hot_b_reg;
	logic [POS_W-1:0] prev_reg;
	logic [POS_W-1:0] dif;
	logic [POS_W-1:0] stp;
	assign dif = MICROSTEP_POSITION - prev_reg;
	// the delayed copy covers a last carry in the cycle velocity is cleared
	assign stp = (vnz_reg | vnzd_reg) ? POS_W'(1) : POS_W'(STEP_WIDTH);
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_reg <= 4'h2;
			vnz_reg <= 1'b0;
		end else if (WR) begin
			if (ADDR == 8'h00) cfg_reg <= WDATA[3:0];
			if (ADDR == 8'h04) vnz_reg <= |WDATA[23:0];
		end
	end
	// eight cycles of cause history span the synchronisers and the latch
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			hot_a_reg <= 8'h00;
			hot_b_reg <= 8'h00;
			prev_reg <= '0;
			vnzd_reg <= 1'b0;
		end else begin
			hot_a_reg <= {hot_a_reg[6:0], TEMP_ABOVE_143 | SHORT_GND_A | SHORT_SUP_A};
			hot_b_reg <= {hot_b_reg[6:0], TEMP_ABOVE_143 | SHORT_GND_B | SHORT_SUP_B};
			prev_reg <= MICROSTEP_POSITION;
			vnzd_reg <= vnz_reg;
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
		else $error("read data not zero outside read cycle");
	unmapped_rd_a: assert property ($past(RD) && $past(ADDR) > 8'h10 |-> RDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	cfg_rd_a: assert property ($past(RD) && $past(ADDR) == 8'h00 |-> RDATA[3:0] == $past(cfg_reg))
		else $error("config readback wrong");
	pos_rd_a: assert property ($past(RD) && $past(ADDR) == 8'h0C |-> RDATA[POS_W-1:0] == $past(MICROSTEP_POSITION))
		else $error("position readback wrong");
	idx_zero_a: assert property (!cfg_reg[0] && $changed(MICROSTEP_POSITION) |-> INDEX == (MICROSTEP_POSITION == '0))
		else $error("index not at zero point");
	idx_toggle_a: assert property (cfg_reg[0] && $changed(MICROSTEP_POSITION) |-> INDEX != $past(INDEX))
		else $error("index did not toggle on step");
	step_size_a: assert property (MICROSTEP_POSITION != prev_reg |-> dif == stp || dif == -stp)
		else $error("position moved by wrong amount");
	bridge_a_off_a: assert property ($fell(BRIDGE_A_EN) |-> !cfg_reg[1] || hot_a_reg != 8'h00)
		else $error("bridge A off without cause");
	bridge_b_off_a: assert property ($fell(BRIDGE_B_EN) |-> !cfg_reg[1] || hot_b_reg != 8'h00)
		else $error("bridge B off without cause");
endmodule
bind stpidx_core stpidx_monitor #(.POS_W(POS_W)) u_mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STEP_WIDTH(STEP_WIDTH), .TEMP_ABOVE_143(TEMP_ABOVE_143),
	.SHORT_GND_A(SHORT_GND_A), .SHORT_SUP_A(SHORT_SUP_A), .SHORT_GND_B(SHORT_GND_B), .SHORT_SUP_B(SHORT_SUP_B),
	.INDEX(INDEX), .BRIDGE_A_EN(BRIDGE_A_EN), .BRIDGE_B_EN(BRIDGE_B_EN), .MICROSTEP_POSITION(MICROSTEP_POSITION));
`default_nettype wire

// ===== dv/stpidx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module stpidx_host_model (
	// clock
	input  wire logic clk,
	// command from bench
	input  wire logic req,
	input  wire logic dir,
	// pins toward the driver
	output logic      step_pin,
	output logic      dir_pin,
	output logic      busy
);
	logic [3:0] cnt_reg = 4'h0;
	logic       dir_reg = 1'b0;
	// dir settles two clocks ahead of the rising step and holds after it
	always_ff @(posedge clk) begin
		if (req && cnt_reg == 4'h0) begin
			cnt_reg <= 4'h8;
			dir_reg <= dir;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	assign step_pin = (cnt_reg <= 4'h6) && (cnt_reg >= 4'h3);
	assign dir_pin  = dir_reg;
	assign busy     = (cnt_reg != 4'h0);
endmodule
`default_nettype wire

// ===== dv/tb_stpidx_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stpidx_core;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        req = 1'b0;
	logic        dirv = 1'b0;
	logic        busy;
	logic        step_pin;
	logic        dir_pin;
	logic [8:0]  step_width = 9'h100;
	logic        otp_th150 = 1'b0;
	logic        otp_pw143 = 1'b0;
	logic [3:0]  temp = 4'h0;
	logic [3:0]  shrt = 4'h0;
	logic        index;
	logic        bra;
	logic        brb;
	logic [9:0]  pos;
	logic [31:0] d0;
	logic [31:0] d1;
	int          n_fail = 0;
	int          cmp_count = 0;
	stpidx_core u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .STEP_PIN(step_pin), .DIR_PIN(dir_pin), .STEP_WIDTH(step_width),
		.OTP_TH_150(otp_th150), .OTP_PW_143(otp_pw143), .TEMP_ABOVE_120(temp[0]), .TEMP_ABOVE_143(temp[1]),
		.TEMP_ABOVE_150(temp[2]), .TEMP_ABOVE_157(temp[3]), .SHORT_GND_A(shrt[0]), .SHORT_SUP_A(shrt[1]),
		.SHORT_GND_B(shrt[2]), .SHORT_SUP_B(shrt[3]), .INDEX(index), .BRIDGE_A_EN(bra), .BRIDGE_B_EN(brb),
		.MICROSTEP_POSITION(pos));
	stpidx_host_model u_host (.clk(clk_sys), .req(req), .dir(dirv), .step_pin(step_pin), .dir_pin(dir_pin),
		.busy(busy));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic step(input logic d);
		@(posedge clk_sys);
		req <= 1'b1;
		dirv <= d;
		@(posedge clk_sys);
		req <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 16 && busy === 1'b1; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// twenty clocks between the two position captures
	task automatic span(output logic [31:0] v);
		rreg(8'h0C, d0);
		repeat (18) @(posedge clk_sys);
		rreg(8'h0C, d1);
		v = (d1 - d0) & 32'h0000_03FF;
	endtask
	task automatic tmp(input logic [3:0] t, input logic on);
		@(posedge clk_sys);
		temp <= t;
		repeat (6) @(posedge clk_sys);
		#1 chk({bra, brb}, {on, on});
	endtask
	task automatic spk(input logic [3:0] s);
		@(posedge clk_sys);
		shrt <= s;
		repeat (4) @(posedge clk_sys);
		shrt <= 4'h0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic t_reset();
		rreg(8'h00, d0);
		chk(d0 & 32'h0000_000F, 32'h0000_0002);
		rreg(8'h10, d0);
		chk(d0, 32'h0000_0000);
		rreg(8'h40, d0);
		chk(d0, 32'h0000_0000);
		chk({index, bra, brb}, 3'b111);
	endtask
	task automatic t_ext();
		for (int k = 1; k <= 4; k++) begin
			step(1'b0);
			chk(32'(pos), 32'((k * 256) % 1024));
			chk(32'(index), 32'(k == 4));
		end
		step(1'b1);
		chk(32'(pos), 32'h0000_0300);
		step(1'b0);
		chk(32'(index), 32'h0000_0001);
		// a narrower step width, up then back down to zero
		@(posedge clk_sys);
		step_width <= 9'h040;
		step(1'b0);
		chk(32'(pos), 32'h0000_0040);
		step(1'b1);
		chk(32'(pos), 32'h0000_0000);
		@(posedge clk_sys);
		step_width <= 9'h100;
	endtask
	task automatic t_vel();
		wreg(8'h04, 32'h0020_0000);
		wreg(8'h04, 32'h0040_0000);
		span(d1);
		chk(d1, 32'h0000_0005);
		rreg(8'h08, d1);
		chk(d1, 32'h0000_0004);
		wreg(8'h04, 32'h00C0_0000);
		span(d1);
		chk(d1, 32'h0000_03FB);
		wreg(8'h04, 32'h0000_0000);
		span(d1);
		chk(d1, 32'h0000_0000);
		step(1'b0);
		chk(32'(pos), (d0 + 32'h0000_0100) & 32'h0000_03FF);
	endtask
	task automatic t_istep();
		logic i0;
		wreg(8'h00, 32'h0000_0003);
		// index follows the new mode one clock after the write lands
		repeat (2) @(posedge clk_sys);
		#1 i0 = index;
		step(1'b0);
		chk(32'(index), 32'(!i0));
		step(1'b0);
		chk(32'(index), 32'(i0));
		wreg(8'h00, 32'h0000_0002);
	endtask
	task automatic t_temp();
		tmp(4'h1, 1'b1);
		rreg(8'h10, d0);
		chk(d0 & 32'h0000_0003, 32'h0000_0002);
		tmp(4'h3, 1'b0);
		tmp(4'h1, 1'b0);
		tmp(4'h0, 1'b1);
		wreg(8'h00, 32'h0000_000E);
		tmp(4'h7, 1'b1);
		tmp(4'hF, 1'b0);
		tmp(4'h3, 1'b0);
		tmp(4'h1, 1'b1);
		wreg(8'h00, 32'h0000_0006);
		tmp(4'h7, 1'b0);
		rreg(8'h10, d0);
		chk(d0 & 32'h0000_0001, 32'h0000_0001);
		tmp(4'h1, 1'b0);
		tmp(4'h0, 1'b1);
		wreg(8'h00, 32'h0000_000A);
		tmp(4'h7, 1'b0);
		tmp(4'h1, 1'b1);
		tmp(4'h0, 1'b1);
		wreg(8'h00, 32'h0000_0002);
	endtask
	// one bridge per pass, ground short on A then supply short on B
	task automatic t_short();
		for (int b = 0; b < 2; b++) begin
			repeat (3) spk(b ? 4'h8 : 4'h1);
			chk({bra, brb}, 2'b11);
			spk(b ? 4'h8 : 4'h1);
			chk({bra, brb}, b ? 2'b10 : 2'b01);
			rreg(8'h10, d0);
			chk(d0 & 32'h0000_00FF, b ? 32'h0000_00A0 : 32'h0000_0044);
			wreg(8'h00, 32'h0000_0000);
			wreg(8'h00, 32'h0000_0002);
			rreg(8'h10, d0);
			chk(d0, 32'h0000_0000);
			chk({bra, brb}, 2'b11);
		end
	endtask
	// mid-run reset with the 150 strap set; prewarn 120 on the first pass, 143 on the second
	task automatic t_otp();
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys);
			otp_th150 <= 1'b1;
			otp_pw143 <= 1'(p);
			reset_n <= 1'b0;
			repeat (3) @(posedge clk_sys);
			reset_n <= 1'b1;
			#1 chk({index, bra, brb, pos}, 13'h0C00);
			tmp(4'h3, 1'b1);
			chk(32'(index), 32'h0000_0001);
			rreg(8'h00, d0);
			chk(d0, 32'h0000_0002);
			tmp(4'h7, 1'b0);
			tmp(4'h3, 1'b0);
			tmp(4'h1, p == 1);
			tmp(4'h0, 1'b1);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_ext();
		t_vel();
		t_istep();
		t_temp();
		t_short();
		t_otp();
		print_verdict();
	end
	// the sequence needs well under a thousand clocks; this allows several times that
	initial begin
		#200_000;
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
